// ### hdl/usm_cfg.svh
`ifndef USM_CFG_SVH
`define USM_CFG_SVH

// Register byte offsets on the APB window
`define USM_OFS_CONTROL 8'h00
`define USM_OFS_DATA 8'h04
`define USM_OFS_BAUD 8'h08
`define USM_OFS_RELOAD 8'h0C
`define USM_OFS_PINCFG 8'h10
`define USM_OFS_STATUS 8'h14

// Field positions in serial_control
`define USM_CTL_RX_DONE 0
`define USM_CTL_TX_DONE 1
`define USM_CTL_RX_NINTH 2
`define USM_CTL_TX_NINTH 3
`define USM_CTL_RX_ENABLE 4
`define USM_CTL_MODE_LO 6
`define USM_CTL_MODE_HI 7

// Field positions in the baud register
`define USM_BAUD_SOURCE 0
`define USM_BAUD_DOUBLE 1
`define USM_BAUD_IRQ_EN 2

// Field positions in the pin configuration register
`define USM_PIN_OD_TX 0
`define USM_PIN_OD_RX 1

// Reset values
`define USM_RST_RELOAD 10'h000
`define USM_RST_BYTE 8'h00
`define USM_RST_WORD 32'h0000_0000

// Timing counts
`define USM_SYNC_LAST 4'hB
`define USM_SYNC_HALF 4'h6
`define USM_OS_LAST 4'hF
`define USM_OS_MID 4'h7
`define USM_GEN_TOP 10'h3FF
`define USM_PRE_DIV4 2'h3
`define USM_PRE_DIV2 2'h1
`define USM_PRE_DIV1 2'h0
`define USM_BITS8 4'h8
`define USM_BITS9 4'h9
`define USM_SYNC_BITS 4'h7

`endif

// ### hdl/usm_pkg.sv
package usm_pkg;

  // Two-bit mode field
  typedef enum logic [1:0] {
    USM_MODE_SYNC = 2'b00,
    USM_MODE_ASYNC8 = 2'b01,
    USM_MODE_ASYNC9_FIXED = 2'b10,
    USM_MODE_ASYNC9_VAR = 2'b11
  } usm_mode_t;

  // Sequencer states, shared by transmitter and receiver
  typedef enum logic [2:0] {
    USM_SEQ_IDLE = 3'b000,
    USM_SEQ_START = 3'b001,
    USM_SEQ_DATA = 3'b010,
    USM_SEQ_STOP = 3'b011,
    USM_SEQ_SHIFT = 3'b100
  } usm_seq_t;

  // One pin as level plus output enable
  typedef struct packed {
    logic level;
    logic drive;
  } usm_pin_t;

endpackage : usm_pkg

// ### hdl/usm_uart.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "usm_cfg.svh"
module usm_uart
  import usm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t1_overflow,
  input wire usm_pin_t gpio_tx,
  input wire usm_pin_t gpio_rx,
  output usm_pin_t serial_tx_pin,
  input wire logic serial_rx_pin_in,
  output usm_pin_t serial_rx_pin,
  output logic serial_irq
);

  // Control and configuration state
  usm_mode_t mode, next_mode;
  logic receive_enable, next_receive_enable;
  logic tx_ninth_bit, next_tx_ninth_bit;
  logic rx_ninth_bit, next_rx_ninth_bit;
  logic tx_done_flag, next_tx_done_flag;
  logic rx_done_flag, next_rx_done_flag;
  logic serial_irq_enable, next_serial_irq_enable;
  logic baud_source_select, next_baud_source_select;
  logic baud_double, next_baud_double;
  logic [9:0] baud_reload, next_baud_reload;
  logic od_tx, next_od_tx;
  logic od_rx, next_od_rx;
  logic [7:0] serial_data_buffer, next_serial_data_buffer;
  logic [31:0] next_prdata;
  // Baud tick generator
  logic [9:0] gen_cnt, next_gen_cnt;
  logic [1:0] pre_cnt, next_pre_cnt;
  logic tick, next_tick;
  // Transmitter
  usm_seq_t tx_state, next_tx_state;
  logic [8:0] tx_shift, next_tx_shift;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic tx_line, next_tx_line;
  logic sclk, next_sclk;
  // Receiver
  usm_seq_t rx_state, next_rx_state;
  logic [8:0] rx_shift, next_rx_shift;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_bit, next_rx_bit;
  logic rx_meta, rx_sync, rx_prev;
  // Pins
  usm_pin_t next_tx_pin, next_rx_pin;

  logic access, wr, setup, ctl_hit, mapped, open_reg;
  logic nine, base_evt, tx_set, rx_set;
  logic [1:0] pre_max;
  logic [3:0] nbits;
  usm_pin_t tx_raw, rx_raw;

  // Zero-wait-state slave; read data is latched in the setup phase
  assign pready = 1'b1;
  assign access = psel & penable;
  assign setup = psel & ~penable;
  assign wr = access & pwrite;
  assign ctl_hit = paddr == `USM_OFS_CONTROL;
  // Registers other than control and pins hide while the port is off
  assign open_reg = receive_enable;
  assign mapped = ctl_hit | (paddr == `USM_OFS_DATA)
    | (paddr == `USM_OFS_BAUD) | (paddr == `USM_OFS_RELOAD)
    | (paddr == `USM_OFS_PINCFG) | (paddr == `USM_OFS_STATUS);
  assign pslverr = access & ~mapped;
  assign nine = mode[1];
  assign nbits = nine ? `USM_BITS9 : `USM_BITS8;
  // One enable, one request line for both directions
  assign serial_irq = serial_irq_enable
    & (tx_done_flag | rx_done_flag);

  // Two-flop synchroniser on the receive pin; rx_sync and its delayed copy rx_prev are used
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= serial_rx_pin_in;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Baud source: the fixed 9-bit mode counts every clock
  always_comb
  begin
    if (mode == USM_MODE_ASYNC9_FIXED)
      base_evt = 1'b1;
    else if (baud_source_select)
      base_evt = gen_cnt == `USM_GEN_TOP;
    else
      base_evt = t1_overflow;
    // Sixteen-times tick: reload and fixed divide by 4, timer 1 by 2
    if (mode != USM_MODE_ASYNC9_FIXED && !baud_source_select)
      pre_max = baud_double ? `USM_PRE_DIV1 : `USM_PRE_DIV2;
    else
      pre_max = baud_double ? `USM_PRE_DIV2 : `USM_PRE_DIV4;
  end

  // Pin muxing: GPIO owns the pins while the port is off
  always_comb
  begin
    tx_raw.level = (mode == USM_MODE_SYNC) ? sclk : tx_line;
    tx_raw.drive = 1'b1;
    rx_raw.level = tx_line;
    rx_raw.drive = tx_state == USM_SEQ_SHIFT;
    if (!receive_enable)
    begin
      tx_raw = gpio_tx;
      rx_raw = gpio_rx;
    end
    // Open drain only pulls low and ignores the direction setting
    next_tx_pin = od_tx ? usm_pin_t'{level: 1'b0, drive: ~tx_raw.level}
      : tx_raw;
    next_rx_pin = od_rx ? usm_pin_t'{level: 1'b0, drive: ~rx_raw.level}
      : rx_raw;
  end

  // Next state of registers, baud generator and both sequencers
  always_comb
  begin
    next_mode = mode;
    next_receive_enable = receive_enable;
    next_tx_ninth_bit = tx_ninth_bit;
    next_rx_ninth_bit = rx_ninth_bit;
    next_tx_done_flag = tx_done_flag;
    next_rx_done_flag = rx_done_flag;
    next_serial_irq_enable = serial_irq_enable;
    next_baud_source_select = baud_source_select;
    next_baud_double = baud_double;
    next_baud_reload = baud_reload;
    next_od_tx = od_tx;
    next_od_rx = od_rx;
    next_serial_data_buffer = serial_data_buffer;
    next_prdata = prdata;
    next_gen_cnt = gen_cnt;
    next_pre_cnt = pre_cnt;
    next_tick = 1'b0;
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_line = tx_line;
    next_sclk = sclk;
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    tx_set = 1'b0;
    rx_set = 1'b0;

    // Read mux, sampled in the setup phase so prdata is a flop
    if (setup)
    begin
      next_prdata = `USM_RST_WORD;
      if (ctl_hit)
        next_prdata[7:0] = {mode, 1'b0, receive_enable, tx_ninth_bit,
          rx_ninth_bit, tx_done_flag, rx_done_flag};
      else if (paddr == `USM_OFS_PINCFG)
        next_prdata[1:0] = {od_rx, od_tx};
      else if (open_reg && paddr == `USM_OFS_DATA)
        next_prdata[7:0] = serial_data_buffer;
      else if (open_reg && paddr == `USM_OFS_BAUD)
        next_prdata[2:0] = {serial_irq_enable, baud_double,
          baud_source_select};
      else if (open_reg && paddr == `USM_OFS_RELOAD)
        next_prdata[9:0] = baud_reload;
      else if (open_reg && paddr == `USM_OFS_STATUS)
        next_prdata[1:0] = {rx_state != USM_SEQ_IDLE,
          tx_state != USM_SEQ_IDLE};
    end

    // Register writes; flags take software values, hardware sets later
    if (wr && ctl_hit)
    begin
      next_receive_enable = pwdata[`USM_CTL_RX_ENABLE];
      next_tx_done_flag = pwdata[`USM_CTL_TX_DONE];
      next_rx_done_flag = pwdata[`USM_CTL_RX_DONE];
      if (open_reg)
      begin
        next_mode = usm_mode_t'(pwdata[`USM_CTL_MODE_HI:`USM_CTL_MODE_LO]);
        next_tx_ninth_bit = pwdata[`USM_CTL_TX_NINTH];
        next_rx_ninth_bit = pwdata[`USM_CTL_RX_NINTH];
      end
    end
    if (wr && paddr == `USM_OFS_PINCFG)
    begin
      next_od_tx = pwdata[`USM_PIN_OD_TX];
      next_od_rx = pwdata[`USM_PIN_OD_RX];
    end
    if (wr && open_reg && paddr == `USM_OFS_BAUD)
    begin
      next_baud_source_select = pwdata[`USM_BAUD_SOURCE];
      next_baud_double = pwdata[`USM_BAUD_DOUBLE];
      next_serial_irq_enable = pwdata[`USM_BAUD_IRQ_EN];
    end
    if (wr && open_reg && paddr == `USM_OFS_RELOAD)
      next_baud_reload = pwdata[9:0];

    // Everything below halts while the port is disabled
    if (receive_enable)
    begin
      // Reload counter wraps every 1024 - reload clocks
      next_gen_cnt = (gen_cnt == `USM_GEN_TOP) ? baud_reload
        : gen_cnt + 10'h001;
      if (base_evt)
      begin
        next_pre_cnt = (pre_cnt >= pre_max) ? 2'h0 : pre_cnt + 2'h1;
        next_tick = pre_cnt >= pre_max;
      end

      // Transmitter; writes while busy are dropped
      unique case (tx_state)
        USM_SEQ_IDLE:
        begin
          if (wr && paddr == `USM_OFS_DATA)
          begin
            next_tx_shift = {tx_ninth_bit, pwdata[7:0]};
            next_tx_cnt = 4'h0;
            next_tx_bit = 4'h0;
            if (mode == USM_MODE_SYNC)
            begin
              next_tx_state = USM_SEQ_SHIFT;
              next_tx_line = pwdata[0];
              next_sclk = 1'b0;
            end
            else
            begin
              next_tx_state = USM_SEQ_START;
              next_tx_line = 1'b0;
            end
          end
        end
        USM_SEQ_START, USM_SEQ_DATA, USM_SEQ_STOP:
        begin
          if (tick)
          begin
            next_tx_cnt = tx_cnt + 4'h1;
            if (tx_cnt == `USM_OS_LAST)
            begin
              if (tx_state == USM_SEQ_START)
              begin
                next_tx_state = USM_SEQ_DATA;
                next_tx_line = tx_shift[0];
              end
              else if (tx_state == USM_SEQ_DATA
                && tx_bit + 4'h1 == nbits)
              begin
                next_tx_state = USM_SEQ_STOP;
                next_tx_line = 1'b1;
                tx_set = 1'b1;
              end
              else if (tx_state == USM_SEQ_DATA)
              begin
                next_tx_bit = tx_bit + 4'h1;
                next_tx_shift = {1'b0, tx_shift[8:1]};
                next_tx_line = tx_shift[1];
              end
              else
                next_tx_state = USM_SEQ_IDLE;
            end
          end
        end
        USM_SEQ_SHIFT:
        begin
          // Twelve clocks per bit: low half, then rising shift clock
          next_tx_cnt = (tx_cnt == `USM_SYNC_LAST) ? 4'h0
            : tx_cnt + 4'h1;
          next_sclk = next_tx_cnt >= `USM_SYNC_HALF;
          if (tx_cnt == `USM_SYNC_LAST)
          begin
            next_tx_bit = tx_bit + 4'h1;
            next_tx_shift = {1'b0, tx_shift[8:1]};
            next_tx_line = tx_shift[1];
            if (tx_bit == `USM_SYNC_BITS)
            begin
              next_tx_state = USM_SEQ_IDLE;
              next_tx_line = 1'b1;
              next_sclk = 1'b1;
              tx_set = 1'b1;
            end
          end
        end
        default:
          next_tx_state = USM_SEQ_IDLE;
      endcase

      // Receiver runs beside the transmitter for full duplex
      unique case (rx_state)
        USM_SEQ_IDLE:
        begin
          next_rx_cnt = 4'h0;
          next_rx_bit = 4'h0;
          if (mode == USM_MODE_SYNC)
          begin
            // Clearing a set receive-done flag kicks off a sync read
            if (wr && ctl_hit && rx_done_flag
              && !pwdata[`USM_CTL_RX_DONE] && tx_state == USM_SEQ_IDLE)
            begin
              next_rx_state = USM_SEQ_SHIFT;
              next_sclk = 1'b0;
            end
          end
          else if (rx_prev && !rx_sync)
            next_rx_state = USM_SEQ_START;
        end
        USM_SEQ_START, USM_SEQ_DATA, USM_SEQ_STOP:
        begin
          if (tick)
          begin
            next_rx_cnt = rx_cnt + 4'h1;
            if (rx_cnt == `USM_OS_MID)
            begin
              if (rx_state == USM_SEQ_START && rx_sync)
                next_rx_state = USM_SEQ_IDLE; // Glitch, not a start
              else if (rx_state == USM_SEQ_DATA)
              begin
                next_rx_shift = {rx_sync, rx_shift[8:1]};
                next_rx_bit = rx_bit + 4'h1;
              end
              else if (rx_state == USM_SEQ_STOP)
              begin
                next_rx_state = USM_SEQ_IDLE;
                rx_set = 1'b1;
                next_serial_data_buffer = nine ? rx_shift[7:0]
                  : rx_shift[8:1];
                next_rx_ninth_bit = nine ? rx_shift[8] : rx_sync;
              end
            end
            else if (rx_cnt == `USM_OS_LAST)
            begin
              if (rx_state == USM_SEQ_START)
                next_rx_state = USM_SEQ_DATA;
              else if (rx_bit == nbits)
                next_rx_state = USM_SEQ_STOP;
            end
          end
        end
        USM_SEQ_SHIFT:
        begin
          next_rx_cnt = (rx_cnt == `USM_SYNC_LAST) ? 4'h0
            : rx_cnt + 4'h1;
          next_sclk = next_rx_cnt >= `USM_SYNC_HALF;
          if (rx_cnt == `USM_SYNC_HALF)
            next_rx_shift = {rx_sync, rx_shift[8:1]};
          if (rx_cnt == `USM_SYNC_LAST)
          begin
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == `USM_SYNC_BITS)
            begin
              next_rx_state = USM_SEQ_IDLE;
              next_sclk = 1'b1;
              rx_set = 1'b1;
              next_serial_data_buffer = rx_shift[8:1];
            end
          end
        end
        default:
          next_rx_state = USM_SEQ_IDLE;
      endcase
    end

    // Hardware sets win over a same-cycle software clear
    if (tx_set)
      next_tx_done_flag = 1'b1;
    if (rx_set)
      next_rx_done_flag = 1'b1;
  end

  // State registers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      mode <= USM_MODE_SYNC;
      receive_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      serial_irq_enable <= 1'b0;
      baud_source_select <= 1'b0;
      baud_double <= 1'b0;
      baud_reload <= `USM_RST_RELOAD;
      od_tx <= 1'b0;
      od_rx <= 1'b0;
      serial_data_buffer <= `USM_RST_BYTE;
      prdata <= `USM_RST_WORD;
      gen_cnt <= `USM_RST_RELOAD;
      pre_cnt <= 2'h0;
      tick <= 1'b0;
      tx_state <= USM_SEQ_IDLE;
      tx_shift <= 9'h000;
      tx_cnt <= 4'h0;
      tx_bit <= 4'h0;
      tx_line <= 1'b1;
      sclk <= 1'b1;
      rx_state <= USM_SEQ_IDLE;
      rx_shift <= 9'h000;
      rx_cnt <= 4'h0;
      rx_bit <= 4'h0;
      serial_tx_pin <= '{level: 1'b0, drive: 1'b0};
      serial_rx_pin <= '{level: 1'b0, drive: 1'b0};
    end
    else
    begin
      mode <= next_mode;
      receive_enable <= next_receive_enable;
      tx_ninth_bit <= next_tx_ninth_bit;
      rx_ninth_bit <= next_rx_ninth_bit;
      tx_done_flag <= next_tx_done_flag;
      rx_done_flag <= next_rx_done_flag;
      serial_irq_enable <= next_serial_irq_enable;
      baud_source_select <= next_baud_source_select;
      baud_double <= next_baud_double;
      baud_reload <= next_baud_reload;
      od_tx <= next_od_tx;
      od_rx <= next_od_rx;
      serial_data_buffer <= next_serial_data_buffer;
      prdata <= next_prdata;
      gen_cnt <= next_gen_cnt;
      pre_cnt <= next_pre_cnt;
      tick <= next_tick;
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_line <= next_tx_line;
      sclk <= next_sclk;
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      serial_tx_pin <= next_tx_pin;
      serial_rx_pin <= next_rx_pin;
    end
  end

endmodule : usm_uart

// ### tb/tb.sv
`timescale 1ns/100ps
`include "usm_cfg.svh"
module tb
  import usm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic t1_overflow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serial_irq, serial_rx_pin_in, far_rx, tx_wire, err;
  usm_pin_t gpio_tx = 2'b11;
  usm_pin_t gpio_rx = 2'b10;
  usm_pin_t serial_tx_pin, serial_rx_pin;
  int n_errors = 0;
  int n_checks = 0;

  // Clock, and a timer overflow pulse every second cycle
  always #20 clock = ~clock;
  always @(posedge clock)
    t1_overflow <= ~t1_overflow;

  // Released tx line rests on its pull-up; released rx line is driven by the far end
  assign tx_wire = serial_tx_pin.drive ? serial_tx_pin.level : 1'b1;
  assign serial_rx_pin_in = serial_rx_pin.drive ? serial_rx_pin.level : far_rx;

  usm_uart uut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t1_overflow(t1_overflow),
    .gpio_tx(gpio_tx), .gpio_rx(gpio_rx), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin_in(serial_rx_pin_in), .serial_rx_pin(serial_rx_pin),
    .serial_irq(serial_irq)
  );
  usm_far_end far (
    .clock(clock), .tx_line(tx_wire), .rx_wire(serial_rx_pin_in),
    .rx_line(far_rx)
  );

  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One bus transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] m, e);
    apb(1'b0, a, 16'h0000);
    chk(n, e, rd & m);
  endtask : rchk

  // Poll a control flag; the bound keeps a dead flag from hanging us
  task automatic wflag(input int b);
    rd = 32'h0;
    for (int i = 0; i < 2000 && rd[b] !== 1'b1; i++)
      apb(1'b0, `USM_OFS_CONTROL, 16'h0000);
  endtask : wflag

  task automatic t_regs;
    rchk("ctl reset", `USM_OFS_CONTROL, 32'hFFFF_FFFF, 32'h0);
    rchk("pin reset", `USM_OFS_PINCFG, 32'hFFFF_FFFF, 32'h0);
    wr(`USM_OFS_BAUD, 16'h0007);
    rchk("baud hidden", `USM_OFS_BAUD, 32'hFFFF_FFFF, 32'h0);
    wr(`USM_OFS_CONTROL, 16'h0010);
    wr(`USM_OFS_BAUD, 16'h0003);
    rchk("baud", `USM_OFS_BAUD, 32'hFFFF_FFFF, 32'h3);
    apb(1'b0, 8'h40, 16'h0000);
    chk("slverr", 32'h1, {31'h0, err});
  endtask : t_regs

  task automatic t_pins;
    wr(`USM_OFS_CONTROL, 16'h0000);
    gpio_tx <= 2'b01;
    gpio_rx <= 2'b11;
    repeat (3) @(posedge clock);
    chk("gpio pins", 32'h7, {28'h0, serial_tx_pin, serial_rx_pin});
    gpio_tx <= 2'b11;
    wr(`USM_OFS_CONTROL, 16'h0010);
    wr(`USM_OFS_CONTROL, 16'h0050);
    repeat (8) @(posedge clock);
    wr(`USM_OFS_PINCFG, 16'h0001);
    repeat (3) @(posedge clock);
    chk("od tx", 32'h0, 32'(serial_tx_pin));
    wr(`USM_OFS_PINCFG, 16'h0000);
  endtask : t_pins

  // Full-duplex frame pair, then flags and interrupt gating
  task automatic t_async(input logic [1:0] m, input logic [15:0] b, rl,
    input int c);
    int n0;
    n0 = far.n_got;
    far.bit_clks = c;
    far.nbits = m[1] ? 9 : 8;
    far.listen = 1'b1;
    wr(`USM_OFS_CONTROL, {8'h00, m, 6'h18});
    wr(`USM_OFS_BAUD, b);
    wr(`USM_OFS_RELOAD, rl);
    // A new reload only takes hold when the counter next wraps
    repeat (1040) @(posedge clock);
    fork
      wr(`USM_OFS_DATA, 16'h00A5);
      far.send(9'h03C);
    join
    wflag(0);
    rchk("rx byte", `USM_OFS_DATA, 32'hFF, 32'h3C);
    rchk("rx ninth", `USM_OFS_CONTROL, 32'h4, m[1] ? 32'h0 : 32'h4);
    wait (far.n_got > n0);
    chk("tx frame", m[1] ? 32'h3A5 : 32'h1A5, 32'(far.got));
    rchk("tx done", `USM_OFS_CONTROL, 32'h2, 32'h2);
    wr(`USM_OFS_BAUD, b | 16'h0004);
    @(posedge clock);
    chk("irq on", 32'h1, 32'(serial_irq));
    wr(`USM_OFS_BAUD, b);
    @(posedge clock);
    chk("irq masked", 32'h0, 32'(serial_irq));
    wr(`USM_OFS_CONTROL, {8'h00, m, 6'h18});
    wr(`USM_OFS_BAUD, b | 16'h0004);
    @(posedge clock);
    chk("irq cleared", 32'h0, 32'(serial_irq));
    wr(`USM_OFS_BAUD, b);
  endtask : t_async

  task automatic t_sync;
    far.listen = 1'b0;
    far.sync_on = 1'b1;
    wr(`USM_OFS_CONTROL, 16'h0010);
    wr(`USM_OFS_DATA, 16'h0096);
    wflag(1);
    chk("sync tx", 32'h96, 32'(far.sgot));
    wr(`USM_OFS_CONTROL, 16'h0011);
    fork
      wr(`USM_OFS_CONTROL, 16'h0010);
      far.shift_in(8'h5B);
    join
    wflag(0);
    rchk("sync rx", `USM_OFS_DATA, 32'hFF, 32'h5B);
  endtask : t_sync

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Main sequence; rates cover reload, timer, fixed and doubled sources
  initial
  begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_async(2'b01, 16'h0001, 16'h03FE, 128);
    t_async(2'b01, 16'h0000, 16'h03FF, 64);
    t_async(2'b11, 16'h0003, 16'h03FF, 32);
    t_async(2'b10, 16'h0000, 16'h03FF, 64);
    t_async(2'b10, 16'h0002, 16'h03FF, 32);
    t_sync();
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(40 * 40000);
    n_errors++;
    give_verdict();
  end
endmodule : tb

bind usm_uart usm_uart_monitor mon (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .t1_overflow(t1_overflow),
  .gpio_tx(gpio_tx), .gpio_rx(gpio_rx), .serial_tx_pin(serial_tx_pin),
  .serial_rx_pin_in(serial_rx_pin_in), .serial_rx_pin(serial_rx_pin),
  .serial_irq(serial_irq)
);

// ### tb/usm_far_end.sv
`timescale 1ns/100ps
module usm_far_end
(
  input wire logic clock,
  input wire logic tx_line,
  input wire logic rx_wire,
  output logic rx_line
);
  int bit_clks = 64;
  int nbits = 8;
  int n_got = 0;
  logic listen = 1'b0;
  logic sync_on = 1'b0;
  logic [9:0] got = 10'h000;
  logic [7:0] sgot = 8'h00;

  // Idle line held high so no false start is seen
  initial rx_line = 1'b1;

  // Frame out: start, data LSB first, stop
  task automatic send(input logic [8:0] d);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge clock);
    for (int i = 0; i < nbits; i++)
    begin
      rx_line <= d[i];
      repeat (bit_clks) @(posedge clock);
    end
    rx_line <= 1'b1;
    repeat (bit_clks) @(posedge clock);
  endtask : send

  // Shift mode: new bit on each falling shift clock
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge tx_line);
      rx_line <= d[i];
    end
    @(posedge tx_line);
    repeat (6) @(posedge clock);
    rx_line <= 1'b1;
  endtask : shift_in

  // Frame in, sampled at bit centres; the stop bit lands above the data
  always
  begin
    @(negedge tx_line iff listen);
    got = 10'h000;
    repeat (bit_clks / 2) @(posedge clock);
    for (int i = 0; i <= nbits; i++)
    begin
      repeat (bit_clks) @(posedge clock);
      got[i] = tx_line;
    end
    n_got++;
  end

  // Shift mode capture on the rising shift clock
  always @(posedge tx_line)
    if (sync_on)
      sgot <= {rx_wire, sgot[7:1]};
endmodule : usm_far_end

// ### tb/usm_uart_monitor.sv
`timescale 1ns/100ps
`include "usm_cfg.svh"
module usm_uart_monitor
  import usm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic t1_overflow,
  input wire usm_pin_t gpio_tx,
  input wire usm_pin_t gpio_rx,
  input wire usm_pin_t serial_tx_pin,
  input wire logic serial_rx_pin_in,
  input wire usm_pin_t serial_rx_pin,
  input wire logic serial_irq
);
  logic wr_ok, en, ie, od, next_en, next_ie, next_od, tx;
  logic [1:0] mode, next_mode;

  // Shadow of enable, mode, interrupt enable and open drain
  always_comb
  begin
    wr_ok = psel && penable && pwrite && pready;
    next_en = en;
    next_ie = ie;
    next_od = od;
    next_mode = mode;
    if (wr_ok && paddr == `USM_OFS_CONTROL)
    begin
      next_en = pwdata[`USM_CTL_RX_ENABLE];
      if (en)
        next_mode = pwdata[`USM_CTL_MODE_HI:`USM_CTL_MODE_LO];
    end
    if (wr_ok && en && paddr == `USM_OFS_BAUD)
      next_ie = pwdata[`USM_BAUD_IRQ_EN];
    if (wr_ok && paddr == `USM_OFS_PINCFG)
      next_od = pwdata[`USM_PIN_OD_TX];
  end

  // Cleared on reset so the shadow never leads the port
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      {en, ie, od, mode} <= 5'h00;
    else
      {en, ie, od, mode} <= {next_en, next_ie, next_od, next_mode};
  end

  assign tx = serial_tx_pin.level;

  default clocking mon_clk @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("transfer not answered at once");

  property p_unmapped;
    psel && penable && paddr > `USM_OFS_STATUS |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");

  property p_irq_gate;
    !ie |-> !serial_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt while disabled");

  property p_start;
    psel && penable && pwrite && paddr == `USM_OFS_DATA && en
      && mode != 2'b00 && !od && tx |-> ##[1:3] !tx;
  endproperty
  a_start: assert property (p_start)
    else $error("no start bit after data write");

  // Pins still carry their reset value on the first edge after release
  property p_gpio;
    rst_b && !en ##1 !en |-> serial_tx_pin == $past(gpio_tx)
      && serial_rx_pin == $past(gpio_rx);
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("disabled pins do not follow gpio");

  property p_od;
    en && od ##1 en && od |-> !tx;
  endproperty
  a_od: assert property (p_od)
    else $error("open drain pin driven high");

  property p_clk_low;
    en && mode == 2'b00 && $fell(tx) |-> !tx [*6] ##1 tx;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("shift clock low phase wrong");

  property p_clk_high;
    en && mode == 2'b00 && $rose(tx) |-> tx [*6];
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("shift clock high phase wrong");
endmodule : usm_uart_monitor
